// *** design/pin_filter.sv ***
`timescale 1ns/1ps
module pin_filter (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_pin_n,
	output logic      o_reset_level
);
	typedef struct packed {
		logic       s1;
		logic       s2;
		logic [2:0] cnt;
		logic       lvl;
	} pf_state_t;

	pf_state_t s_q;
	pf_state_t s_d;

	assign o_reset_level = s_q.lvl;

	// ==========================================================
	// Sync then debounce; short pulses never reach the level
	always_comb begin
		s_d    = s_q;
		s_d.s1 = ~i_pin_n;
		s_d.s2 = s_q.s1;
		if (s_q.s2 == s_q.lvl) begin
			s_d.cnt = 3'h0;
		end else if (s_q.cnt == 3'(rstseq_pkg::PIN_FILTER_CYC - 1)) begin
			s_d.cnt = 3'h0;
			s_d.lvl = s_q.s2;
		end else begin
			s_d.cnt = s_q.cnt + 3'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// *** design/reset_sequencer.sv ***
`timescale 1ns/1ps
module reset_sequencer (
	input  wire logic                    I_CORE_CLK,
	input  wire logic                    I_RESET_N,
	input  wire logic                    i_por_event,
	input  wire logic                    i_bor_event,
	input  wire logic                    i_pin_reset_n,
	input  wire logic                    i_sw_reset,
	input  wire logic                    i_wdt_timeout,
	input  wire logic                    i_int_wake,
	input  wire logic                    i_trap_reset,
	input  wire logic                    i_illegal_op,
	input  wire logic                    i_sleeping,
	input  wire logic                    i_idling,
	input  wire logic                    i_first_phase_clock,
	input  wire rstseq_pkg::fuse_cfg_t   i_fuse,
	input  wire rstseq_pkg::clk_status_t i_clk_status,
	input  wire logic [31:0]             S_AXI_AWADDR,
	input  wire logic                    S_AXI_AWVALID,
	output logic                         S_AXI_AWREADY,
	input  wire logic [31:0]             S_AXI_WDATA,
	input  wire logic [3:0]              S_AXI_WSTRB,
	input  wire logic                    S_AXI_WVALID,
	output logic                         S_AXI_WREADY,
	output logic [1:0]                   S_AXI_BRESP,
	output logic                         S_AXI_BVALID,
	input  wire logic                    S_AXI_BREADY,
	input  wire logic [31:0]             S_AXI_ARADDR,
	input  wire logic                    S_AXI_ARVALID,
	output logic                         S_AXI_ARREADY,
	output logic [31:0]                  S_AXI_RDATA,
	output logic [1:0]                   S_AXI_RRESP,
	output logic                         S_AXI_RVALID,
	input  wire logic                    S_AXI_RREADY,
	output logic                         o_internal_system_reset,
	output logic [23:0]                  o_fetch_addr,
	output logic                         o_fetch_load,
	output logic                         o_clock_fail_trap,
	output logic [1:0]                   o_clk_source,
	output logic                         o_clock_gate,
	output logic                         o_wake
);
	typedef struct packed {
		rstseq_pkg::seq_state_t st;
		logic [31:0]            cnt;
		logic [31:0]            pwrt_cyc;
		logic                   boot;
		logic [15:0]            cause;
		logic                   cf;
		logic [1:0]             clk_src;
		logic                   rst;
		logic [23:0]            fetch;
		logic                   fload;
		logic                   trap;
		logic                   gate;
		logic                   wake;
		logic                   q1_s3;
		logic [2:0]             ev_s1;
		logic [2:0]             ev_s2;
		logic                   pin_prev;
		logic                   aw_ok;
		logic [7:0]             aw_a;
		logic                   w_ok;
		logic [31:0]            w_d;
		logic [3:0]             w_s;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
		logic                   aw_rdy;
		logic                   w_rdy;
		logic                   ar_rdy;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;
	logic       pin_level;

	// ==========================================================
	// Pin path: sync and noise filter, input only
	pin_filter u_pin_filter (
		.i_clk         (I_CORE_CLK),
		.i_rst_n       (I_RESET_N),
		.i_pin_n       (i_pin_reset_n),
		.o_reset_level (pin_level)
	);

	assign S_AXI_AWREADY           = s_q.aw_rdy;
	assign S_AXI_WREADY            = s_q.w_rdy;
	assign S_AXI_BVALID            = s_q.bvalid;
	assign S_AXI_BRESP             = s_q.bresp;
	assign S_AXI_ARREADY           = s_q.ar_rdy;
	assign S_AXI_RVALID            = s_q.rvalid;
	assign S_AXI_RDATA             = s_q.rdata;
	assign S_AXI_RRESP             = s_q.rresp;
	assign o_internal_system_reset = s_q.rst;
	assign o_fetch_addr            = s_q.fetch;
	assign o_fetch_load            = s_q.fload;
	assign o_clock_fail_trap       = s_q.trap;
	assign o_clk_source            = s_q.clk_src;
	assign o_clock_gate            = s_q.gate;
	assign o_wake                  = s_q.wake;

	function automatic logic [31:0] pwrt_cycles(input logic [1:0] sel, input logic xtal);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (sel)
			2'd0: r = xtal ? 32'(rstseq_pkg::MONITOR_SETTLE_CYC) : 32'h0000_0000;
			2'd1: r = 32'(rstseq_pkg::PWRT_4_CYC);
			2'd2: r = 32'(rstseq_pkg::PWRT_16_CYC);
			2'd3: r = 32'(rstseq_pkg::PWRT_64_CYC);
		endcase
		return r;
	endfunction

	// ==========================================================
	// Sequencer, cause flags and bus
	always_comb begin
		logic por_ev;
		logic bor_ev;
		logic sw_ev;
		logic pin_rise;
		logic clk_ok;
		logic start;
		logic aw_go;
		logic w_go;
		logic [31:0] wv;
		por_ev   = 1'b0;
		bor_ev   = 1'b0;
		sw_ev    = 1'b0;
		pin_rise = 1'b0;
		clk_ok   = 1'b0;
		start    = 1'b0;
		aw_go    = 1'b0;
		w_go     = 1'b0;
		wv       = 32'h0000_0000;
		s_d      = s_q;

		s_d.ev_s1 = {i_por_event, i_bor_event, i_first_phase_clock};
		s_d.ev_s2 = s_q.ev_s1;
		s_d.q1_s3 = s_q.ev_s2[0];
		// First cycle out of reset is a power-on, so fuses get sampled
		s_d.boot  = 1'b0;
		por_ev    = s_q.ev_s2[2] | s_q.boot;
		bor_ev    = s_q.ev_s2[1] & ~por_ev;
		sw_ev     = i_sw_reset & (s_q.st == rstseq_pkg::ST_RUN);
		s_d.pin_prev = pin_level;
		pin_rise  = pin_level & ~s_q.pin_prev;
		s_d.fload = 1'b0;
		s_d.trap  = 1'b0;
		s_d.wake  = 1'b0;
		clk_ok    = i_clk_status.osc_running & ~i_clk_status.ost_busy
			& (~i_fuse.pll_used | i_clk_status.pll_lock);

		// Software write first so hardware set wins on same cycle
		aw_go = S_AXI_AWVALID & ~s_q.aw_ok;
		w_go  = S_AXI_WVALID & ~s_q.w_ok;
		if (aw_go) begin
			s_d.aw_ok = 1'b1;
			s_d.aw_a  = S_AXI_AWADDR[7:0];
		end
		if (w_go) begin
			s_d.w_ok = 1'b1;
			s_d.w_d  = S_AXI_WDATA;
			s_d.w_s  = S_AXI_WSTRB;
		end
		if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
			s_d.aw_ok  = 1'b0;
			s_d.w_ok   = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = rstseq_pkg::RESP_OKAY;
			wv = {{8{s_q.w_s[3]}}, {8{s_q.w_s[2]}}, {8{s_q.w_s[1]}}, {8{s_q.w_s[0]}}};
			if (s_q.aw_a == rstseq_pkg::ADDR_CAUSE) begin
				s_d.cause = (s_q.cause & ~wv[15:0]) | (s_q.w_d[15:0] & wv[15:0]);
			end else if (s_q.aw_a != rstseq_pkg::ADDR_OSC && s_q.aw_a != rstseq_pkg::ADDR_STAT) begin
				s_d.bresp = rstseq_pkg::RESP_SLVERR;
			end
		end
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid = 1'b0;
		end
		if (S_AXI_ARVALID && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = rstseq_pkg::RESP_OKAY;
			unique case (S_AXI_ARADDR[7:0])
				rstseq_pkg::ADDR_CAUSE: s_d.rdata = {16'h0000, s_q.cause};
				rstseq_pkg::ADDR_OSC: s_d.rdata = {26'h000_0000, i_clk_status.pll_lock,
					1'b0, s_q.cf, 1'b0, s_q.clk_src};
				rstseq_pkg::ADDR_STAT: s_d.rdata = {24'h00_0000, s_q.gate, s_q.rst, 2'b00,
					s_q.st};
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = rstseq_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid = 1'b0;
		end

		// Cause flag updates per reset kind
		if (por_ev) begin
			s_d.cause = rstseq_pkg::CAUSE_POR_VAL;
			start     = 1'b1;
		end else if (bor_ev) begin
			s_d.cause[rstseq_pkg::BIT_BOR] = 1'b1;
			s_d.cause[rstseq_pkg::BIT_POR] = 1'b0;
			start = 1'b1;
		end else if (pin_rise) begin
			s_d.cause[rstseq_pkg::BIT_PIN_RESET_FLAG] = 1'b1;
			s_d.cause[rstseq_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
			if (i_sleeping) begin
				s_d.cause[rstseq_pkg::BIT_SLEEP] = 1'b1;
				s_d.cause[rstseq_pkg::BIT_IDLE]  = 1'b0;
			end else if (i_idling) begin
				s_d.cause[rstseq_pkg::BIT_IDLE]  = 1'b1;
				s_d.cause[rstseq_pkg::BIT_SLEEP] = 1'b0;
			end else begin
				s_d.cause[rstseq_pkg::BIT_SWR]   = 1'b0;
				s_d.cause[rstseq_pkg::BIT_IDLE]  = 1'b0;
				s_d.cause[rstseq_pkg::BIT_SLEEP] = 1'b0;
			end
			start = 1'b1;
		end else if (s_q.st == rstseq_pkg::ST_RUN && i_wdt_timeout && i_sleeping) begin
			s_d.cause[rstseq_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b1;
			s_d.cause[rstseq_pkg::BIT_SLEEP] = 1'b1;
			s_d.wake = 1'b1;
		end else if (s_q.st == rstseq_pkg::ST_RUN && i_wdt_timeout) begin
			// Watchdog counts on its own RC outside this clock
			s_d.cause[rstseq_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b1;
			s_d.cause[rstseq_pkg::BIT_PIN_RESET_FLAG]  = 1'b0;
			s_d.cause[rstseq_pkg::BIT_SWR]   = 1'b0;
			s_d.cause[rstseq_pkg::BIT_IDLE]  = 1'b0;
			s_d.cause[rstseq_pkg::BIT_SLEEP] = 1'b0;
			start = 1'b1;
		end else if (sw_ev) begin
			s_d.cause[rstseq_pkg::BIT_SWR]   = 1'b1;
			s_d.cause[rstseq_pkg::BIT_PIN_RESET_FLAG]  = 1'b0;
			s_d.cause[rstseq_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
			s_d.cause[rstseq_pkg::BIT_IDLE]  = 1'b0;
			s_d.cause[rstseq_pkg::BIT_SLEEP] = 1'b0;
			start = 1'b1;
		end else if (s_q.st == rstseq_pkg::ST_RUN && i_trap_reset) begin
			s_d.cause[rstseq_pkg::BIT_TRAP] = 1'b1;
			start = 1'b1;
		end else if (s_q.st == rstseq_pkg::ST_RUN && i_illegal_op) begin
			s_d.cause[rstseq_pkg::BIT_IOP] = 1'b1;
			start = 1'b1;
		end else if (s_q.st == rstseq_pkg::ST_RUN && i_int_wake && i_sleeping) begin
			s_d.cause[rstseq_pkg::BIT_SLEEP] = 1'b1;
			s_d.wake = 1'b1;
		end

		// Reset sequence
		if (start) begin
			s_d.st       = rstseq_pkg::ST_HOLD;
			s_d.cnt      = 32'h0000_0000;
			s_d.rst      = 1'b1;
			s_d.pwrt_cyc = pwrt_cycles(i_fuse.pwrt_sel, i_fuse.crystal);
			if (por_ev || bor_ev) begin
				s_d.clk_src = i_fuse.osc_group;
				s_d.cf      = 1'b0;
			end
		end else if (pin_level) begin
			s_d.st  = rstseq_pkg::ST_HOLD;
			s_d.cnt = 32'h0000_0000;
			s_d.rst = 1'b1;
		end else begin
			unique case (s_q.st)
				rstseq_pkg::ST_HOLD: begin
					s_d.st = rstseq_pkg::ST_BIAS;
				end
				rstseq_pkg::ST_BIAS: begin
					if (s_q.cnt >= 32'(rstseq_pkg::BIAS_SETTLE_CYC - 1)) begin
						s_d.cnt = 32'h0000_0000;
						s_d.st  = rstseq_pkg::ST_PWRT;
					end else begin
						s_d.cnt = s_q.cnt + 32'h0000_0001;
					end
				end
				rstseq_pkg::ST_PWRT: begin
					if (s_q.cnt >= s_q.pwrt_cyc) begin
						// Release waits for a first-phase rising edge after settle
						if (s_q.q1_s3 == 1'b0 && s_q.ev_s2[0] == 1'b1) begin
							s_d.st    = rstseq_pkg::ST_RUN;
							s_d.rst   = 1'b0;
							s_d.fetch = rstseq_pkg::RESET_VECTOR;
							s_d.fload = 1'b1;
							if (i_fuse.clock_fail_monitor_en && !clk_ok) begin
								s_d.trap    = 1'b1;
								s_d.cf      = 1'b1;
								s_d.clk_src = rstseq_pkg::OSC_FRC;
							end
						end
					end else begin
						s_d.cnt = s_q.cnt + 32'h0000_0001;
					end
				end
				rstseq_pkg::ST_RUN: begin
				end
			endcase
		end

		// Clock gated in reset, and for a crystal until the oscillator is good (and locked when a PLL is used) or clock fail is set
		s_d.gate = ~s_q.rst & (clk_ok | s_q.cf | ~i_fuse.crystal);

		// Ready flops mirror the next busy state, so outputs stay registered
		s_d.aw_rdy = ~s_d.aw_ok;
		s_d.w_rdy  = ~s_d.w_ok;
		s_d.ar_rdy = ~s_d.rvalid;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			s_q       <= '0;
			s_q.st    <= rstseq_pkg::ST_HOLD;
			s_q.rst   <= 1'b1;
			s_q.cause <= rstseq_pkg::CAUSE_POR_VAL;
			s_q.boot   <= 1'b1;
			s_q.aw_rdy <= 1'b1;
			s_q.w_rdy  <= 1'b1;
			s_q.ar_rdy <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// *** pkg/rstseq_pkg.sv ***
package rstseq_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_MHZ            = 200;
	localparam int unsigned BIAS_SETTLE_US     = 10;
	localparam int unsigned MONITOR_SETTLE_US  = 100;
	localparam int unsigned PWRT_4_MS          = 4;
	localparam int unsigned PWRT_16_MS         = 16;
	localparam int unsigned PWRT_64_MS         = 64;
	localparam int unsigned BIAS_SETTLE_CYC    = BIAS_SETTLE_US * CLK_MHZ;
	localparam int unsigned MONITOR_SETTLE_CYC = MONITOR_SETTLE_US * CLK_MHZ;
	localparam int unsigned PWRT_4_CYC         = PWRT_4_MS * 1000 * CLK_MHZ;
	localparam int unsigned PWRT_16_CYC        = PWRT_16_MS * 1000 * CLK_MHZ;
	localparam int unsigned PWRT_64_CYC        = PWRT_64_MS * 1000 * CLK_MHZ;
	localparam int unsigned PIN_FILTER_CYC     = 4;
	localparam int unsigned DELAY_W            = 24;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_CAUSE = 8'h00;
	localparam logic [7:0] ADDR_OSC   = 8'h04;
	localparam logic [7:0] ADDR_STAT  = 8'h08;

	// Cause and OSC register bit positions
	localparam int unsigned BIT_POR    = 0;
	localparam int unsigned BIT_BOR    = 1;
	localparam int unsigned BIT_IDLE   = 2;
	localparam int unsigned BIT_SLEEP  = 3;
	localparam int unsigned BIT_WATCHDOG_TIMEOUT_FLAG   = 4;
	localparam int unsigned BIT_SWR    = 6;
	localparam int unsigned BIT_PIN_RESET_FLAG   = 7;
	localparam int unsigned BIT_IOP    = 14;
	localparam int unsigned BIT_TRAP   = 15;
	localparam int unsigned BIT_LOCK   = 5;
	localparam int unsigned BIT_CF     = 3;
	localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;

	localparam logic [23:0] RESET_VECTOR = 24'h00_0000;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Clock source groups
	localparam logic [1:0] OSC_FRC = 2'b01;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		ST_HOLD  = 4'b0001,
		ST_BIAS  = 4'b0010,
		ST_PWRT  = 4'b0100,
		ST_RUN   = 4'b1000
	} seq_state_t;

	typedef struct packed {
		logic       clock_fail_monitor_en;
		logic [1:0] pwrt_sel;
		logic       crystal;
		logic       pll_used;
		logic [1:0] osc_group;
	} fuse_cfg_t;

	typedef struct packed {
		logic osc_running;
		logic ost_busy;
		logic pll_lock;
	} clk_status_t;

endpackage

// *** test/far_side_model.sv ***
`timescale 1ns/1ps
module far_side_model (
	input  wire logic               i_osc_ok,
	output logic                    o_first_phase,
	output rstseq_pkg::clk_status_t o_status
);
	// ==========================================================
	// First phase runs free, unrelated in phase to the core clock
	initial o_first_phase = 1'b0;
	always #7.3 o_first_phase = ~o_first_phase;

	// ==========================================================
	// A dead oscillator also leaves start-up busy and loop unlocked
	assign o_status = '{osc_running: i_osc_ok, ost_busy: !i_osc_ok, pll_lock: i_osc_ok};
endmodule

// *** test/rstseq_assertions.sv ***
`timescale 1ns/1ps
module rstseq_checker (
	input wire logic                  I_CORE_CLK,
	input wire logic                  I_RESET_N,
	input wire logic                  i_por_event,
	input wire logic                  i_bor_event,
	input wire logic                  i_pin_reset_n,
	input wire logic                  i_sw_reset,
	input wire logic                  i_wdt_timeout,
	input wire logic                  i_int_wake,
	input wire logic                  i_sleeping,
	input wire logic                  i_idling,
	input wire rstseq_pkg::fuse_cfg_t i_fuse,
	input wire logic                  o_internal_system_reset,
	input wire logic [23:0]           o_fetch_addr,
	input wire logic                  o_clock_fail_trap,
	input wire logic [1:0]            o_clk_source,
	input wire logic                  o_wake
);
	// ==========================================================
	// Helpers
	logic        sr;
	logic [31:0] cnt_q;
	logic        pwr_q;
	assign sr = o_internal_system_reset;
	// Only power events owe the full bias settle
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			cnt_q <= '0;
			pwr_q <= 1'b1;
		end else begin
			cnt_q <= sr ? cnt_q + 32'd1 : '0;
			if (i_por_event || i_bor_event)
				pwr_q <= 1'b1;
			else if ($fell(sr))
				pwr_q <= 1'b0;
		end
	end

	// ==========================================================
	// Properties
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESET_N);

	por_hold_a: assert property ($rose(i_por_event) |-> ##[1:4] sr)
		else $error("power-on event did not hold reset");
	bias_min_a: assert property ($fell(sr) && pwr_q |-> cnt_q >= rstseq_pkg::BIAS_SETTLE_CYC)
		else $error("reset released before bias settle");
	fetch_vec_a: assert property ($fell(sr) |-> ##[0:1] o_fetch_addr == rstseq_pkg::RESET_VECTOR)
		else $error("release not at reset vector");
	trap_frc_a: assert property (o_clock_fail_trap |-> ##[0:2] o_clk_source == rstseq_pkg::OSC_FRC)
		else $error("clock fail without fast rc switch");
	trap_cause_a: assert property (o_clock_fail_trap |-> i_fuse.clock_fail_monitor_en)
		else $error("clock fail trap with monitor off");
	bor_hold_a: assert property ($rose(i_bor_event) |-> ##[1:4] sr)
		else $error("brown-out did not hold reset");
	pin_hold_a: assert property ((!i_pin_reset_n)[*8] |-> ##[0:2] sr)
		else $error("long pin pulse did not reset");
	sw_hold_a: assert property (i_sw_reset && !sr |-> ##[1:3] sr)
		else $error("software reset ignored");
	wake_run_a: assert property (i_int_wake && i_sleeping && !sr |-> ##[1:3] o_wake && !sr)
		else $error("interrupt wake missing or reset");
	dog_hold_a: assert property (i_wdt_timeout && !i_sleeping && !i_idling && !sr |-> ##[1:4] sr)
		else $error("watchdog timeout did not reset");

	cover property ($fell(sr));
	cover property (o_clock_fail_trap);
	cover property (o_wake);
endmodule

bind reset_sequencer rstseq_checker rstseq_checker_i (.*);

// *** test/tb_reset_sequencer.sv ***
`timescale 1ns/1ps
module tb_reset_sequencer;
	logic clk = 0, rst_n = 0, por = 0, bor = 0, pin_n = 1, software_reset_flag = 0, wdt = 0, iwk = 0;
	logic slp = 0, idl = 0, osc_ok = 1, fp, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wrd, bv, arr, rv, rst_o, fl, trap, gate, wake, trap_seen = 0, wake_seen = 0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rdv;
	logic [23:0] fa;
	logic [1:0] br, rr, cs;
	logic [15:0] rnd = 16'h004B;
	logic clr_seen = 0;
	int num_errors = 0, checks = 0;
	rstseq_pkg::fuse_cfg_t fuse = 7'h02;
	rstseq_pkg::clk_status_t cst;

	always #2.5 clk = ~clk;
	// One process owns the seen flags; scenarios only request a clear
	always @(posedge clk) begin
		if (clr_seen) begin
			trap_seen <= 0;
			wake_seen <= 0;
		end else begin
			if (trap) trap_seen <= 1;
			if (wake) wake_seen <= 1;
		end
	end

	far_side_model far_side_model_i (.i_osc_ok(osc_ok), .o_first_phase(fp), .o_status(cst));
	reset_sequencer reset_sequencer_i (
		.I_CORE_CLK(clk), .I_RESET_N(rst_n), .i_por_event(por), .i_bor_event(bor),
		.i_pin_reset_n(pin_n), .i_sw_reset(software_reset_flag), .i_wdt_timeout(wdt), .i_int_wake(iwk),
		.i_trap_reset(1'b0), .i_illegal_op(1'b0), .i_sleeping(slp), .i_idling(idl),
		.i_first_phase_clock(fp), .i_fuse(fuse), .i_clk_status(cst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
		.o_internal_system_reset(rst_o), .o_fetch_addr(fa), .o_fetch_load(fl),
		.o_clock_fail_trap(trap), .o_clk_source(cs), .o_clock_gate(gate), .o_wake(wake));

	// ==========================================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, s, e);
		end
	endtask

	task complete_run;
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task tmo;
		num_errors++;
		$display("[ERR] %0t wait ran out", $time);
		complete_run();
	endtask

	// ==========================================================
	// Bus master
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		awaddr <= 32'(a);
		wdata <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
			if (bv) break;
		end
		if (n == 40) tmo();
		bry <= 0;
		chk(br, er);
	endtask

	task rd(input logic [7:0] a, input logic [1:0] er);
		int n;
		@(posedge clk);
		araddr <= 32'(a);
		arv <= 1;
		rry <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arr) arv <= 0;
			if (rv) break;
		end
		if (n == 40) tmo();
		rry <= 0;
		rdv = rdata;
		chk(rr, er);
	endtask

	// ==========================================================
	// Reset events
	task run_wait;
		int n;
		for (n = 0; n < 30000; n++) begin
			@(posedge clk);
			if (!rst_o) break;
		end
		if (n == 30000) tmo();
		chk(fa, rstseq_pkg::RESET_VECTOR);
		chk(fl, 1);
	endtask

	task ev(input int k, input logic s, input logic i, input logic [15:0] pre, input logic [15:0] ex);
		wr(rstseq_pkg::ADDR_CAUSE, 32'(pre), rstseq_pkg::RESP_OKAY);
		@(posedge clk);
		slp <= s;
		idl <= i;
		clr_seen <= 1;
		case (k)
			0: software_reset_flag <= 1;
			1: pin_n <= 0;
			2, 4: wdt <= 1;
			3: bor <= 1;
			5: iwk <= 1;
			default: por <= 1;
		endcase
		// Async sources stay long enough to pass sync and filter
		repeat ((k == 1 || k == 3 || k == 6) ? 10 : 1) @(posedge clk);
		{software_reset_flag, wdt, iwk, bor, por, pin_n} <= 6'h01;
		clr_seen <= 0;
		repeat (6) @(posedge clk);
		if (k == 4 || k == 5) begin
			chk(wake_seen, 1);
			chk(rst_o, 0);
		end else begin
			chk(rst_o, 1);
			run_wait();
		end
		slp <= 0;
		idl <= 0;
		rd(rstseq_pkg::ADDR_CAUSE, rstseq_pkg::RESP_OKAY);
		chk(rdv, 32'(ex));
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		rd(rstseq_pkg::ADDR_CAUSE, rstseq_pkg::RESP_OKAY);
		chk(rdv, 32'(rstseq_pkg::CAUSE_POR_VAL));
		run_wait();
		rd(rstseq_pkg::ADDR_OSC, rstseq_pkg::RESP_OKAY);
		chk(rdv[1:0], fuse.osc_group);
		chk(cs, fuse.osc_group);
		chk(gate, 1);
		// Short pin glitch must die in the filter
		pin_n <= 0;
		repeat (2) @(posedge clk);
		pin_n <= 1;
		repeat (12) @(posedge clk);
		chk(rst_o, 0);
		repeat (6) begin
			rnd = lfsr(rnd);
			wr(rstseq_pkg::ADDR_CAUSE, 32'(rnd & 16'hC0DF), rstseq_pkg::RESP_OKAY);
			rd(rstseq_pkg::ADDR_CAUSE, rstseq_pkg::RESP_OKAY);
			chk(rdv, 32'(rnd & 16'hC0DF));
		end
		wr(8'h0C, 32'hFFFF_FFFF, rstseq_pkg::RESP_SLVERR);
		rd(8'h0C, rstseq_pkg::RESP_SLVERR);
		chk(rdv, 0);
		ev(0, 0, 0, 16'hC09F, 16'hC043);
		ev(1, 0, 0, 16'hC05F, 16'hC083);
		ev(1, 1, 0, 16'hC057, 16'hC0CB);
		ev(1, 0, 1, 16'hC04B, 16'hC0C7);
		ev(2, 0, 0, 16'hC0CF, 16'hC013);
		ev(3, 0, 0, 16'hC0DD, 16'hC0DE);
		ev(3, 1, 0, 16'h0009, 16'h000A);
		ev(4, 1, 0, 16'hC003, 16'hC01B);
		ev(5, 1, 0, 16'hC003, 16'hC00B);
		ev(6, 0, 0, 16'hC0DC, 16'h0003);
		// Crystal with a dead oscillator and no monitor: clock stays gated
		fuse.crystal <= 1;
		osc_ok <= 0;
		ev(3, 0, 0, 16'h0000, 16'h0002);
		chk(gate, 0);
		osc_ok <= 1;
		repeat (3) @(posedge clk);
		chk(gate, 1);
		fuse.clock_fail_monitor_en <= 1;
		osc_ok <= 0;
		ev(3, 0, 0, 16'h0000, 16'h0002);
		repeat (20) @(posedge clk);
		chk(trap_seen, 1);
		chk(cs, rstseq_pkg::OSC_FRC);
		chk(gate, 1);
		rd(rstseq_pkg::ADDR_OSC, rstseq_pkg::RESP_OKAY);
		chk({rdv[3], rdv[1:0]}, {1'b1, rstseq_pkg::OSC_FRC});
		complete_run();
	end
endmodule
